/* logic/icw_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "icw_cfg.svh"
module icw_ctrl
  import icw_pkg::*;
#(
  parameter bit IS_SLAVE = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] pending_i,
  input wire logic [7:0] in_service_i,
  output logic [7:0] rdata_o,
  output logic [7:0] request_mask_register_o,
  output logic nested_priority_select_o,
  output logic auto_end_of_service_o,
  output logic special_mask_on_o,
  output logic poll_o,
  output logic cmd_valid_o,
  output icw_cmd_t cmd_o,
  output logic [2:0] level_select_o,
  output logic [3:0] sys_level_o
);
  icw_seq_t seq_r, seq_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic nest_r, nest_nxt, auto_r, auto_nxt, smm_r, smm_nxt, poll_r, poll_nxt;
  logic ris_r, ris_nxt, cv_r, cv_nxt;
  icw_cmd_t cmd_r, cmd_nxt, dec_cmd;
  logic [2:0] lvl_r, lvl_nxt, dec_lvl;
  logic [7:0] rdata_r, rdata_nxt;
  logic even_wr, odd_wr;

  icw_cmd_decode u_dec (
    .word_i(wdata_i),
    .cmd_o(dec_cmd),
    .level_o(dec_lvl)
  );

  assign even_wr = wr_i && (addr_i == `ICW_ADDR_EVEN);
  assign odd_wr = wr_i && (addr_i == `ICW_ADDR_ODD);

  always_comb begin
    seq_nxt = seq_r;
    mask_nxt = mask_r;
    nest_nxt = nest_r;
    auto_nxt = auto_r;
    smm_nxt = smm_r;
    poll_nxt = poll_r;
    ris_nxt = ris_r;
    cv_nxt = 1'b0;
    cmd_nxt = cmd_r;
    lvl_nxt = lvl_r;
    rdata_nxt = rdata_r;
    if (even_wr && wdata_i[`ICW_BIT_INIT]) begin
      // First init word resets modes and restarts sequence
      seq_nxt = ICW_ST_W2;
      mask_nxt = `ICW_MASK_RST;
      smm_nxt = 1'b0;
      ris_nxt = 1'b0;
      poll_nxt = 1'b0;
      nest_nxt = 1'b0;
      auto_nxt = 1'b0;
    end else if (odd_wr && seq_r != ICW_ST_RUN) begin
      case (seq_r)
        ICW_ST_W2: seq_nxt = ICW_ST_W3;
        ICW_ST_W3: seq_nxt = ICW_ST_W4;
        ICW_ST_W4: begin
          nest_nxt = wdata_i[`ICW_BIT_NEST];
          auto_nxt = wdata_i[`ICW_BIT_AUTO];
          seq_nxt = ICW_ST_RUN;
        end
        default: seq_nxt = ICW_ST_RUN;
      endcase
    end else if (odd_wr) begin
      mask_nxt = wdata_i;
    end else if (even_wr && seq_r == ICW_ST_RUN) begin
      if (!wdata_i[`ICW_BIT_OP3]) begin
        cv_nxt = 1'b1;
        cmd_nxt = dec_cmd;
        lvl_nxt = dec_lvl;
      end else begin
        if (wdata_i[`ICW_BIT_SPECIAL_MASK_WRITE_ENABLE]) begin
          smm_nxt = wdata_i[`ICW_BIT_SMM];
        end
        poll_nxt = wdata_i[`ICW_BIT_POLL];
        if (wdata_i[`ICW_BIT_RR]) begin
          ris_nxt = wdata_i[`ICW_BIT_RIS];
        end
      end
    end
    // Poll state is one-shot; a read of the even address consumes it
    if (rd_i && poll_r && addr_i == `ICW_ADDR_EVEN) begin
      poll_nxt = 1'b0;
    end
    if (rd_i) begin
      if (addr_i == `ICW_ADDR_ODD) begin
        rdata_nxt = mask_r;
      end else begin
        rdata_nxt = ris_r ? in_service_i : pending_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      seq_r <= ICW_ST_RUN;
      mask_r <= `ICW_MASK_RST;
      nest_r <= 1'b0;
      auto_r <= 1'b0;
      smm_r <= 1'b0;
      poll_r <= 1'b0;
      ris_r <= 1'b0;
      cv_r <= 1'b0;
      cmd_r <= ICW_CMD_NONE;
      lvl_r <= 3'h0;
      rdata_r <= 8'h00;
    end else begin
      seq_r <= seq_nxt;
      mask_r <= mask_nxt;
      nest_r <= nest_nxt;
      auto_r <= auto_nxt;
      smm_r <= smm_nxt;
      poll_r <= poll_nxt;
      ris_r <= ris_nxt;
      cv_r <= cv_nxt;
      cmd_r <= cmd_nxt;
      lvl_r <= lvl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign request_mask_register_o = mask_r;
  assign nested_priority_select_o = nest_r;
  assign auto_end_of_service_o = auto_r;
  assign special_mask_on_o = smm_r;
  assign poll_o = poll_r;
  assign cmd_valid_o = cv_r;
  assign cmd_o = cmd_r;
  assign level_select_o = lvl_r;
  // Slave levels offset into the upper half of the system range
  assign sys_level_o = IS_SLAVE ? (`ICW_LVL_BASE_SLAVE | {1'b0, lvl_r}) : {1'b0, lvl_r};
endmodule : icw_ctrl
`default_nettype wire

/* include/icw_cfg.svh */
`ifndef ICW_CFG_SVH
`define ICW_CFG_SVH
`define ICW_ADDR_EVEN 1'b0
`define ICW_ADDR_ODD 1'b1
`define ICW_BIT_INIT 4
`define ICW_BIT_OP3 3
`define ICW_BIT_NEST 4
`define ICW_BIT_AUTO 1
`define ICW_BIT_EOS 5
`define ICW_BIT_SPEC 6
`define ICW_BIT_ROT 7
`define ICW_BIT_SMM 5
`define ICW_BIT_SPECIAL_MASK_WRITE_ENABLE 6
`define ICW_BIT_POLL 2
`define ICW_BIT_RR 1
`define ICW_BIT_RIS 0
`define ICW_MASK_RST 8'h00
`define ICW_LVL_BASE_SLAVE 4'h8
`endif

/* include/icw_pkg.sv */
package icw_pkg;
  typedef enum logic [1:0] {ICW_ST_W2, ICW_ST_W3, ICW_ST_W4, ICW_ST_RUN} icw_seq_t;
  typedef enum logic [2:0] {
    ICW_CMD_NONE, ICW_CMD_EOS, ICW_CMD_SPEC_EOS, ICW_CMD_ROT_EOS,
    ICW_CMD_ROT_AUTO_SET, ICW_CMD_ROT_AUTO_CLR, ICW_CMD_SET_PRIO, ICW_CMD_ROT_SPEC_EOS
  } icw_cmd_t;
endpackage : icw_pkg

/* logic/icw_cmd_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "icw_cfg.svh"
module icw_cmd_decode
  import icw_pkg::*;
(
  input wire logic [7:0] word_i,
  output icw_cmd_t cmd_o,
  output logic [2:0] level_o
);
  always_comb begin
    case (word_i[`ICW_BIT_ROT:`ICW_BIT_EOS])
      3'h1: cmd_o = ICW_CMD_EOS;
      3'h3: cmd_o = ICW_CMD_SPEC_EOS;
      3'h5: cmd_o = ICW_CMD_ROT_EOS;
      3'h4: cmd_o = ICW_CMD_ROT_AUTO_SET;
      3'h0: cmd_o = ICW_CMD_ROT_AUTO_CLR;
      3'h6: cmd_o = ICW_CMD_SET_PRIO;
      3'h7: cmd_o = ICW_CMD_ROT_SPEC_EOS;
      default: cmd_o = ICW_CMD_NONE;
    endcase
    // Level only meaningful with the specific flag
    level_o = word_i[`ICW_BIT_SPEC] ? word_i[2:0] : 3'h0;
  end
endmodule : icw_cmd_decode
`default_nettype wire

/* verif/icw_ctrl_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module icw_ctrl_chk #(parameter bit IS_SLAVE = 1'b0) (
  input wire logic sys_clk_i, rst_i, addr_i, wr_i, rd_i,
  input wire logic [7:0] wdata_i, rdata_o, request_mask_register_o,
  input wire logic special_mask_on_o, poll_o, cmd_valid_o,
  input wire logic [2:0] level_select_o,
  input wire logic [3:0] sys_level_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire ev = wr_i & ~addr_i;
  wire o2 = ev & ~wdata_i[4] & ~wdata_i[3];
  wire o3 = ev & ~wdata_i[4] & wdata_i[3];
  property p_in; ev && wdata_i[4] |=> request_mask_register_o == 8'h00; endproperty
  a_in: assert property (p_in) else $error("in");
  property p_sm; o3 && wdata_i[6:5] == 2'b11 |=> special_mask_on_o; endproperty
  a_sm: assert property (p_sm) else $error("sm");
  property p_nm; o3 && wdata_i[6:5] == 2'b10 |=> !special_mask_on_o; endproperty
  a_nm: assert property (p_nm) else $error("nm");
  property p_pl; o3 && wdata_i[2] |=> poll_o; endproperty
  a_pl: assert property (p_pl) else $error("pl");
  property p_cv; o2 |=> cmd_valid_o; endproperty
  a_cv: assert property (p_cv) else $error("cv");
  property p_lv; o2 && wdata_i[6] |=> level_select_o == $past(wdata_i[2:0]); endproperty
  a_lv: assert property (p_lv) else $error("lv");
  property p_sl; sys_level_o == {IS_SLAVE, level_select_o}; endproperty
  a_sl: assert property (p_sl) else $error("sl");
  property p_hd; !rd_i |=> $stable(rdata_o); endproperty
  a_hd: assert property (p_hd) else $error("hd");
endmodule : icw_ctrl_chk
bind icw_ctrl icw_ctrl_chk #(.IS_SLAVE(IS_SLAVE)) chk (.*);
`default_nettype wire

/* verif/icw_irq_src.sv */
`timescale 1ns/1ns
`default_nettype none
module icw_irq_src (
  input wire logic sys_clk_i,
  output logic [7:0] pending_o,
  output logic [7:0] in_service_o
);
  logic [7:0] cnt_r = 8'h00;
  // Vectors move every cycle so a stale read shows
  always_ff @(posedge sys_clk_i) cnt_r <= cnt_r + 8'h35;
  assign pending_o = cnt_r;
  assign in_service_o = ~cnt_r;
endmodule : icw_irq_src
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import icw_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, addr_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00, pending_i, in_service_i, rdata_o, request_mask_register_o, e;
  logic nested_priority_select_o, auto_end_of_service_o, special_mask_on_o, poll_o, cmd_valid_o;
  icw_cmd_t cmd_o;
  logic [2:0] level_select_o;
  logic [3:0] sys_level_o;
  int n_errors = 0, comparisons = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  icw_irq_src src (.sys_clk_i, .pending_o(pending_i), .in_service_o(in_service_i));
  icw_ctrl #(.IS_SLAVE(1'b1)) dut (.*);
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %0t %h %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic s);
    @(posedge sys_clk_i);
    addr_i <= 1'b0;
    rd_i <= 1'b1;
    // Source vectors move on posedge; capture what the sampling edge will see
    @(negedge sys_clk_i);
    e = s ? in_service_i : pending_i;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rd
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wr(1'b1, 8'h5A);
    chk(request_mask_register_o, 8'h5A);
    wr(1'b0, 8'h13);
    chk(request_mask_register_o, 8'h00);
    wr(1'b1, 8'h08);
    wr(1'b1, 8'h02);
    wr(1'b1, 8'h12);
    chk({6'h00, nested_priority_select_o, auto_end_of_service_o}, 8'h03);
    wr(1'b1, 8'hA5);
    chk(request_mask_register_o, 8'hA5);
    rd(1'b0);
    wr(1'b0, 8'h0B);
    rd(1'b1);
    wr(1'b0, 8'h0A);
    rd(1'b0);
    wr(1'b0, 8'h68);
    chk({7'h00, special_mask_on_o}, 8'h01);
    wr(1'b0, 8'h48);
    chk({7'h00, special_mask_on_o}, 8'h00);
    wr(1'b0, 8'h0C);
    chk({7'h00, poll_o}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(1'b0, {i[2:0], 2'b00, i[2:0]});
      chk({4'h0, cmd_valid_o, cmd_o}, {5'h01, 3'(24'hF9C40D >> (3 * i))});
      if (i[1]) chk({4'h0, sys_level_o}, {5'h01, i[2:0]});
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
